/* design/sync_serial_pkg.sv */
// Shared constants and carrier types for the serial control and status block.
package sync_serial_pkg;
    // Register byte offsets on the plain register port.
    localparam logic [7:0] OFS_PRESCALE = 8'h20;
    localparam logic [7:0] OFS_DIVISOR = 8'h22;
    localparam logic [7:0] OFS_CONTROL = 8'h24;
    localparam logic [7:0] OFS_LINE_STAT = 8'h26;
    localparam logic [7:0] OFS_STATUS = 8'h28;

    // Control register fields.
    localparam int CTL_TX_IRQ_EN = 7;
    localparam int CTL_RX_IRQ_EN = 6;
    localparam int CTL_TX_ON = 5;
    localparam int CTL_RX_ON = 4;
    localparam logic [7:0] CTL_WRITE_MASK = 8'hf3;

    // Status register fields.
    localparam int STS_TX_DONE = 6;
    localparam int STS_TX_STOP = 5;
    localparam int STS_RX_FULL_STOP = 1;

    // Line status register fields.
    localparam int LST_SBC_LSB = 8;
    localparam int LST_SBC_MSB = 14;
    localparam int LST_SCE = 4;

    // Reset values.
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [15:0] STATUS_RST = 16'h0040;
    localparam logic [7:0] DIVISOR_RST = 8'hff;
    localparam logic [1:0] PRESCALE_RST = 2'h0;
    localparam logic [6:0] SBC_RST = 7'h00;

    // Receive FIFO depth in bytes.
    localparam logic [7:0] FIFO_DEPTH = 8'h80;

    // Clock source selections.
    localparam logic [1:0] CKSRC_INT_IN = 2'h0;
    localparam logic [1:0] CKSRC_INT_OUT = 2'h1;

    // Events from the transmit datapath, all on clk.
    typedef struct packed {
        logic move;
        logic last_bit_sent;
        logic fifo_empty;
        logic fifo_write;
    } tx_evt_t;

    // Events from the receive datapath, all on clk.
    typedef struct packed {
        logic store;
        logic [7:0] count;
    } rx_evt_t;

    // Shift strobes for the datapath.
    typedef struct packed {
        logic fall;
        logic rise;
    } shift_evt_t;
endpackage : sync_serial_pkg

/* design/sync_serial_ctrl_status.sv */
// Control, status and bit-rate logic of the synchronous serial port.
`timescale 1ns/10ps
`default_nettype none

module sync_serial_ctrl_status (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire sync_serial_pkg::tx_evt_t tx_evt,
    input wire sync_serial_pkg::rx_evt_t rx_evt,
    input wire logic sck_pin_i,
    output logic sck_pin_o,
    output logic sck_pin_oe,
    output logic tx_on,
    output logic rx_on,
    output logic tx_hold,
    output logic rx_hold,
    output sync_serial_pkg::shift_evt_t shift,
    output logic tx_irq,
    output logic rx_irq
);

    // Last count of the prescaler for a given exponent.
    function automatic logic [5:0] pre_last(input logic [1:0] n);
        logic [5:0] r;
        r = 6'h00;
        case (n)
            2'h0: r = 6'h00;
            2'h1: r = 6'h03;
            2'h2: r = 6'h0f;
            default: r = 6'h3f;
        endcase
        return r;
    endfunction : pre_last

    // True when the selection takes the clock from the pin.
    function automatic logic is_external(input logic [1:0] sel);
        return sel[1];
    endfunction : is_external

    // True when a strobe addresses the register at the given offset.
    function automatic logic reg_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
        return strobe && (addr == ofs);
    endfunction : reg_hit

    // A flag clears on a status write of 0 to its bit once it was read as 1.
    function automatic logic clear_ok(input logic wr, input logic wbit, input logic armed);
        return wr && !wbit && armed;
    endfunction : clear_ok

    logic [7:0] control_q;
    logic [1:0] prescale_q;
    logic [7:0] divisor_q;
    logic sce_q;
    logic [6:0] sbc_q;
    logic tx_done_q;
    logic tx_stop_q;
    logic rx_stop_q;
    logic tx_stop_armed_q;
    logic rx_stop_armed_q;
    logic [7:0] tx_cnt_q;
    logic [15:0] rdata_q;
    logic [5:0] pre_cnt_q;
    logic [8:0] div_cnt_q;
    logic sck_int_q;
    logic sck_s1_q;
    logic sck_s2_q;
    logic sck_s3_q;
    sync_serial_pkg::shift_evt_t shift_q;

    logic [1:0] clock_src_sel;
    logic tx_irq_enable;
    logic rx_irq_enable;
    logic wr_control;
    logic wr_status;
    logic wr_divisor;
    logic wr_prescale;
    logic wr_line_stat;
    logic rd_status;
    logic tx_stop_set;
    logic rx_stop_set;
    logic tx_stop_clr;
    logic rx_stop_clr;
    logic baud_run;
    logic pre_tick;
    logic [8:0] div_last;
    logic [7:0] rx_count_after;
    logic [7:0] rx_target;
    logic [15:0] rdata_d;

    assign clock_src_sel = control_q[1:0];
    assign tx_irq_enable = control_q[sync_serial_pkg::CTL_TX_IRQ_EN];
    assign rx_irq_enable = control_q[sync_serial_pkg::CTL_RX_IRQ_EN];

    assign wr_control = reg_hit(reg_wr, reg_addr, sync_serial_pkg::OFS_CONTROL);
    assign wr_status = reg_hit(reg_wr, reg_addr, sync_serial_pkg::OFS_STATUS);
    assign wr_divisor = reg_hit(reg_wr, reg_addr, sync_serial_pkg::OFS_DIVISOR);
    assign wr_prescale = reg_hit(reg_wr, reg_addr, sync_serial_pkg::OFS_PRESCALE);
    assign wr_line_stat = reg_hit(reg_wr, reg_addr, sync_serial_pkg::OFS_LINE_STAT);
    assign rd_status = reg_hit(reg_rd, reg_addr, sync_serial_pkg::OFS_STATUS);

    // Control register; reserved bits stay zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            control_q <= sync_serial_pkg::CONTROL_RST;
        end else if (wr_control) begin
            control_q <= reg_wdata[7:0] & sync_serial_pkg::CTL_WRITE_MASK;
        end
    end

    // Bit-rate divisor and prescale selection.
    always_ff @(posedge clk) begin
        if (rst) begin
            divisor_q <= sync_serial_pkg::DIVISOR_RST;
            prescale_q <= sync_serial_pkg::PRESCALE_RST;
        end else begin
            if (wr_divisor) begin
                divisor_q <= reg_wdata[7:0];
            end
            if (wr_prescale) begin
                prescale_q <= reg_wdata[1:0];
            end
        end
    end

    // Stop-count enable and byte count.
    always_ff @(posedge clk) begin
        if (rst) begin
            sce_q <= 1'b0;
            sbc_q <= sync_serial_pkg::SBC_RST;
        end else if (wr_line_stat) begin
            sce_q <= reg_wdata[sync_serial_pkg::LST_SCE];
            sbc_q <= reg_wdata[sync_serial_pkg::LST_SBC_MSB:sync_serial_pkg::LST_SBC_LSB];
        end
    end

    // A status read that sees a flag at 1 arms its clear; any status write disarms.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_stop_armed_q <= 1'b0;
            rx_stop_armed_q <= 1'b0;
        end else if (wr_status) begin
            tx_stop_armed_q <= 1'b0;
            rx_stop_armed_q <= 1'b0;
        end else if (rd_status) begin
            tx_stop_armed_q <= tx_stop_armed_q | tx_stop_q;
            rx_stop_armed_q <= rx_stop_armed_q | rx_stop_q;
        end
    end

    // Writing 1 is ignored; writing 0 clears only an armed flag.
    assign tx_stop_clr = clear_ok(wr_status, reg_wdata[sync_serial_pkg::STS_TX_STOP], tx_stop_armed_q);
    assign rx_stop_clr = clear_ok(wr_status, reg_wdata[sync_serial_pkg::STS_RX_FULL_STOP], rx_stop_armed_q);

    // Bytes moved to the shifter since the last stop.
    always_ff @(posedge clk) begin
        if (rst || !sce_q) begin
            tx_cnt_q <= 8'h00;
        end else if (tx_evt.move) begin
            tx_cnt_q <= tx_stop_set ? 8'h00 : tx_cnt_q + 8'h01;
        end
    end

    assign tx_stop_set = sce_q && tx_evt.move && (tx_cnt_q == {1'b0, sbc_q});

    // The receive target is the programmed count plus one, or a full FIFO.
    assign rx_count_after = rx_evt.count + 8'h01;
    assign rx_target = sce_q ? ({1'b0, sbc_q} + 8'h01) : sync_serial_pkg::FIFO_DEPTH;
    assign rx_stop_set = rx_evt.store && (rx_count_after == rx_target);

    // Stop flags: a set in the same cycle as a clear wins.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_stop_q <= sync_serial_pkg::STATUS_RST[sync_serial_pkg::STS_TX_STOP];
        end else if (tx_stop_set) begin
            tx_stop_q <= 1'b1;
        end else if (tx_stop_clr) begin
            tx_stop_q <= 1'b0;
        end
    end

    // Clearing rx_on does not touch this flag.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_stop_q <= sync_serial_pkg::STATUS_RST[sync_serial_pkg::STS_RX_FULL_STOP];
        end else if (rx_stop_set) begin
            rx_stop_q <= 1'b1;
        end else if (rx_stop_clr) begin
            rx_stop_q <= 1'b0;
        end
    end

    // Transmit done: set at an idle end of a byte, cleared by a FIFO write.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_done_q <= sync_serial_pkg::STATUS_RST[sync_serial_pkg::STS_TX_DONE];
        end else if (tx_evt.last_bit_sent && tx_evt.fifo_empty) begin
            tx_done_q <= 1'b1;
        end else if (tx_evt.fifo_write) begin
            tx_done_q <= 1'b0;
        end
    end

    // Interrupt levels follow flag and enable.
    assign tx_irq = tx_irq_enable && tx_stop_q;
    assign rx_irq = rx_irq_enable && rx_stop_q;

    assign tx_on = control_q[sync_serial_pkg::CTL_TX_ON];
    assign rx_on = control_q[sync_serial_pkg::CTL_RX_ON];

    // A reached stop count holds receive until its flag clears, and transmit while its flag and the stop-count enable are both set.
    assign tx_hold = sce_q && tx_stop_q;
    assign rx_hold = rx_stop_q;

    // Baud generator: prescaler 4^n, then half-bit count of 2*(N+1) ticks.
    assign baud_run = !is_external(clock_src_sel) && (tx_on || rx_on);
    assign pre_tick = baud_run && (pre_cnt_q == pre_last(prescale_q));
    assign div_last = {divisor_q, 1'b1};

    always_ff @(posedge clk) begin
        if (rst || !baud_run) begin
            pre_cnt_q <= 6'h00;
        end else if (pre_tick) begin
            pre_cnt_q <= 6'h00;
        end else begin
            pre_cnt_q <= pre_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !baud_run) begin
            div_cnt_q <= 9'h000;
        end else if (pre_tick) begin
            div_cnt_q <= (div_cnt_q == div_last) ? 9'h000 : div_cnt_q + 9'h001;
        end
    end

    // Internal serial clock idles high between frames.
    always_ff @(posedge clk) begin
        if (rst || !baud_run) begin
            sck_int_q <= 1'b1;
        end else if (pre_tick && (div_cnt_q == div_last)) begin
            sck_int_q <= !sck_int_q;
        end
    end

    // External clock pin passes two flip-flops before any logic looks at it.
    always_ff @(posedge clk) begin
        if (rst) begin
            sck_s1_q <= 1'b1;
            sck_s2_q <= 1'b1;
            sck_s3_q <= 1'b1;
        end else begin
            sck_s1_q <= sck_pin_i;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
        end
    end

    // Shift strobes come from the selected clock source.
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q <= '0;
        end else if (is_external(clock_src_sel)) begin
            shift_q.fall <= sck_s3_q && !sck_s2_q;
            shift_q.rise <= !sck_s3_q && sck_s2_q;
        end else begin
            shift_q.fall <= pre_tick && (div_cnt_q == div_last) && sck_int_q;
            shift_q.rise <= pre_tick && (div_cnt_q == div_last) && !sck_int_q;
        end
    end

    assign shift = shift_q;

    // Pin drives only in internal-clock-out mode.
    assign sck_pin_oe = (clock_src_sel == sync_serial_pkg::CKSRC_INT_OUT);
    assign sck_pin_o = sck_int_q;

    // Read word assembled from the named field positions; unmapped offsets and reserved bits read zero.
    always_comb begin
        rdata_d = 16'h0000;
        case (reg_addr)
            sync_serial_pkg::OFS_PRESCALE: begin
                rdata_d[1:0] = prescale_q;
            end
            sync_serial_pkg::OFS_DIVISOR: begin
                rdata_d[7:0] = divisor_q;
            end
            sync_serial_pkg::OFS_CONTROL: begin
                rdata_d[7:0] = control_q;
            end
            sync_serial_pkg::OFS_LINE_STAT: begin
                rdata_d[sync_serial_pkg::LST_SBC_MSB:sync_serial_pkg::LST_SBC_LSB] = sbc_q;
                rdata_d[sync_serial_pkg::LST_SCE] = sce_q;
            end
            sync_serial_pkg::OFS_STATUS: begin
                rdata_d[sync_serial_pkg::STS_TX_DONE] = tx_done_q;
                rdata_d[sync_serial_pkg::STS_TX_STOP] = tx_stop_q;
                rdata_d[sync_serial_pkg::STS_RX_FULL_STOP] = rx_stop_q;
            end
            default: begin
                rdata_d = 16'h0000;
            end
        endcase
    end

    // Read data stand in the cycle after the read strobe only.
    always_ff @(posedge clk) begin
        if (rst || !reg_rd) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

endmodule : sync_serial_ctrl_status

`default_nettype wire

/* testbench/remote_clk_dev.sv */
// Model of the remote device that supplies the serial clock in external mode.
`timescale 1ns/10ps
`default_nettype none
module remote_clk_dev (
    input wire logic go,
    output logic sck
);
    initial sck = 1'b1;
    // Each frame is eight clock periods; the clock stands high between frames.
    always @(posedge go) begin
        repeat (8) begin
            #17.3 sck = 1'b0;
            #17.3 sck = 1'b1;
        end
    end
endmodule : remote_clk_dev
`default_nettype wire

/* testbench/sync_serial_monitor.sv */
// Concurrent checks on the ports of the serial control and status block.
`timescale 1ns/10ps
`default_nettype none
module sync_serial_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire sync_serial_pkg::rx_evt_t rx_evt,
    input wire logic tx_on,
    input wire logic rx_on,
    input wire logic sck_pin_oe,
    input wire logic tx_hold,
    input wire logic rx_hold,
    input wire logic tx_irq,
    input wire logic rx_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] ctl_q;
    logic [7:0] lst_q;
    wire logic ctl_wr = reg_wr && reg_addr == sync_serial_pkg::OFS_CONTROL;
    wire logic sts_wr = reg_wr && reg_addr == sync_serial_pkg::OFS_STATUS;
    wire logic [7:0] rx_top = lst_q[7] ? {1'b0, lst_q[6:0]} : 8'h7f;
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_q <= 8'h00;
        end else if (ctl_wr) begin
            ctl_q <= reg_wdata[7:0] & sync_serial_pkg::CTL_WRITE_MASK;
        end
    end
    // Keeps the stop-count enable above the stop count.
    always_ff @(posedge clk) begin
        if (rst) begin
            lst_q <= 8'h00;
        end else if (reg_wr && reg_addr == sync_serial_pkg::OFS_LINE_STAT) begin
            lst_q <= {reg_wdata[4], reg_wdata[14:8]};
        end
    end
    rst_clears_a: assert property (disable iff (1'b0) rst |=> !(tx_on | rx_on | sck_pin_oe | tx_irq | rx_irq))
        else $error("outputs not cleared by reset");
    enables_follow_a: assert property (ctl_wr |=> {tx_on, rx_on} == $past(reg_wdata[5:4]))
        else $error("enable outputs wrong");
    pin_dir_a: assert property (sck_pin_oe == (ctl_q[1:0] == 2'h1))
        else $error("clock pin enable wrong");
    tx_irq_on_a: assert property (tx_hold && ctl_q[7] |-> tx_irq)
        else $error("tx irq missing");
    tx_irq_gate_a: assert property (tx_irq |-> ctl_q[7])
        else $error("tx irq without enable");
    rx_irq_lvl_a: assert property (rx_irq == (rx_hold && ctl_q[6]))
        else $error("rx irq level wrong");
    rx_flag_set_a: assert property (rx_evt.store && rx_evt.count == rx_top |=> rx_hold)
        else $error("rx flag not set");
    rx_flag_keep_a: assert property (rx_hold && !(sts_wr && !reg_wdata[1]) |=> rx_hold)
        else $error("rx flag lost");
    rx_no_set_a: assert property (!rx_hold && !rx_evt.store |=> !rx_hold)
        else $error("rx flag set without store");
    cover property (tx_irq);
    cover property (rx_irq);
    cover property (sck_pin_oe);
endmodule : sync_serial_monitor
bind sync_serial_ctrl_status sync_serial_monitor sync_serial_monitor_inst (.clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .rx_evt, .tx_on, .rx_on, .sck_pin_oe, .tx_hold, .rx_hold, .tx_irq, .rx_irq);
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the serial control and status block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic go = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    sync_serial_pkg::tx_evt_t tx_evt = '0;
    sync_serial_pkg::rx_evt_t rx_evt = '0;
    sync_serial_pkg::shift_evt_t shift;
    logic sck_pin_i, sck_pin_o, sck_pin_oe, tx_on, rx_on, tx_hold, rx_hold, tx_irq, rx_irq;
    int fails = 0;
    int num_checks = 0;
    always #2.5 clk = ~clk;
    sync_serial_ctrl_status sync_serial_ctrl_status_inst (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .tx_evt, .rx_evt, .sck_pin_i, .sck_pin_o, .sck_pin_oe, .tx_on, .rx_on, .tx_hold, .rx_hold,
        .shift, .tx_irq, .rx_irq);
    remote_clk_dev remote_clk_dev_inst (.go, .sck(sck_pin_i));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // One-cycle datapath event; the struct fields are passed as packed bits.
    task automatic tick(input logic [3:0] t, input logic [8:0] r);
        @(posedge clk);
        tx_evt <= t;
        rx_evt <= r;
        @(posedge clk);
        tx_evt <= '0;
        rx_evt <= '0;
        #1;
    endtask : tick
    task automatic t_reset;
        rd(8'h24, 16'h0000);
        rd(8'h28, 16'h0040);
        rd(8'h22, 16'h00ff);
        chk({tx_on, rx_on, sck_pin_oe, tx_irq, rx_irq}, 16'h0000);
        $display("reset test done");
    endtask : t_reset
    task automatic t_regs;
        wr(8'h24, 16'h00ff);
        wr(8'h30, 16'h1234);
        rd(8'h30, 16'h0000);
        rd(8'h24, 16'h00f3);
        chk({tx_on, rx_on}, 16'h0003);
        wr(8'h22, 16'h005a);
        rd(8'h22, 16'h005a);
        wr(8'h24, 16'h0000);
        $display("register test done");
    endtask : t_regs
    task automatic t_rx;
        wr(8'h26, 16'h0000);
        wr(8'h24, 16'h0050);
        tick(4'h0, 9'h17e);
        chk(rx_hold, 16'h0000);
        tick(4'h0, 9'h17f);
        chk({rx_hold, rx_irq}, 16'h0003);
        wr(8'h28, 16'h0000);
        wr(8'h24, 16'h0040);
        rd(8'h28, 16'h0042);
        wr(8'h28, 16'h0002);
        rd(8'h28, 16'h0042);
        wr(8'h28, 16'h0000);
        chk({rx_hold, rx_irq}, 16'h0000);
        tick(4'h0, 9'h17f);
        wr(8'h24, 16'h0000);
        chk({rx_hold, rx_irq}, 16'h0002);
        rd(8'h28, 16'h0042);
        wr(8'h28, 16'h0000);
        $display("receive flag test done");
    endtask : t_rx
    task automatic t_tx;
        wr(8'h26, 16'h0210);
        wr(8'h24, 16'h00c0);
        repeat (2) tick(4'h8, 9'h000);
        chk(tx_irq, 16'h0000);
        tick(4'h8, 9'h000);
        chk({tx_hold, tx_irq}, 16'h0003);
        tick(4'h0, 9'h102);
        chk({rx_hold, rx_irq}, 16'h0003);
        rd(8'h28, 16'h0062);
        wr(8'h28, 16'h0000);
        chk({tx_irq, rx_irq}, 16'h0000);
        wr(8'h26, 16'h0000);
        tick(4'h1, 9'h000);
        rd(8'h28, 16'h0000);
        tick(4'h4, 9'h000);
        rd(8'h28, 16'h0000);
        tick(4'h6, 9'h000);
        rd(8'h28, 16'h0040);
        $display("transmit flag test done");
    endtask : t_tx
    task automatic t_sck;
        int t0;
        int r0;
        realtime t_edge;
        wr(8'h22, 16'h0001);
        for (int n = 0; n < 4; n++) begin
            wr(8'h24, 16'h0001);
            wr(8'h20, 16'(n));
            wr(8'h24, 16'h0021);
            chk(sck_pin_oe, 16'h0001);
            @(negedge sck_pin_o);
            t_edge = $realtime;
            @(negedge sck_pin_o);
            chk(16'(int'(($realtime - t_edge) / 5.0)), 16'(8 << (2 * n)));
        end
        wr(8'h24, 16'h0020);
        chk(sck_pin_oe, 16'h0000);
        wr(8'h24, 16'h0012);
        // The internal clock returns to its idle level one edge after the source switch.
        repeat (2) @(negedge clk);
        chk({sck_pin_oe, sck_pin_o}, 16'h0001);
        t0 = 0;
        r0 = 0;
        go = 1'b1;
        repeat (100) begin
            @(negedge clk);
            t0 += shift.fall;
            r0 += shift.rise;
        end
        go = 1'b0;
        chk(16'(t0), 16'h0008);
        chk(16'(r0), 16'h0008);
        $display("serial clock test done");
    endtask : t_sck
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    initial begin
        #40000;
        fails++;
        final_report;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_regs;
        t_rx;
        t_tx;
        t_sck;
        final_report;
    end
endmodule : tb
`default_nettype wire
